/* bench/sbt_far_model.sv */
// far side: arbiter, memory and snooper answering one master
// assumes a single bus clock shared with the master
`default_nettype none
module sbt_far_model
  import sbt_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  input  wire logic       i_park,
  input  wire logic       i_rerun_en,
  input  wire logic       i_retry_en,
  input  wire logic       i_ext_good,
  input  wire logic       i_abus_req,
  input  wire logic       i_dbus_req,
  input  wire sbt_abus_t  i_abus,
  input  wire logic       i_dbus_oe_b,
  output logic            o_abus_grant,
  output logic            o_dbus_grant,
  output logic            o_addr_ack,
  output logic            o_addr_rerun,
  output logic            o_data_ack,
  output logic            o_data_retry,
  output logic            o_ext_reply_ok,
  output logic [63:0]     o_dbus_in
);
  logic        abusy, dbusy, dph, rd, reran, retried;
  logic [2:0]  beat, nb;
  logic [31:0] base, cur;
  logic [63:0] idle;
  assign cur       = base + {26'h0, beat, 3'h0};
  assign o_dbus_in = dph ? {cur, ~cur} : idle;
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      {abusy, dbusy, dph, rd, reran, retried, beat, nb, base} <= '0;
      {o_abus_grant, o_dbus_grant, o_addr_ack, o_addr_rerun} <= '0;
      {o_data_ack, o_data_retry, o_ext_reply_ok} <= '0;
      idle <= 64'h0;
    end
    else
    begin
      idle <= ~idle; // released bus never keeps the last value
      {o_addr_ack, o_addr_rerun, o_data_ack, o_data_retry} <= '0;
      abusy <= (abusy | i_abus_req) & !(o_addr_ack | o_addr_rerun);
      dbusy <= (dbusy | i_dbus_req) & !(o_data_retry | (o_data_ack & beat == nb));
      o_abus_grant <= i_park | abusy;
      o_dbus_grant <= i_park | dbusy;
      if (i_abus.valid && !o_addr_ack && !o_addr_rerun)
      begin
        if (i_rerun_en && !reran)
        begin
          o_addr_rerun <= 1'b1;
          reran        <= 1'b1;
        end
        else
        begin
          o_addr_ack     <= 1'b1;
          reran          <= 1'b0;
          o_ext_reply_ok <= i_ext_good;
          dph  <= i_abus.kind != SBT_ADDR_ONLY && !(i_abus.ext && !i_ext_good);
          rd   <= !i_abus.write;
          beat <= 3'h0;
          nb   <= (i_abus.kind == SBT_BURST) ? 3'h3 : 3'h0;
          base <= (i_abus.kind == SBT_BURST) ? {i_abus.addr[31:5], 5'h00} : {i_abus.addr[31:3], 3'h0};
        end
      end
      if (o_data_ack)
      begin
        beat <= beat + 3'h1;
        if (beat == nb)
          dph <= 1'b0;
      end
      else if (dph && o_dbus_grant && (i_park || dbusy) && !i_dbus_req && !o_addr_ack
               && !o_data_retry && (rd || !i_dbus_oe_b))
      begin
        // retry only on reads: write data replay is left unmodelled
        if (rd && i_retry_en && !retried)
        begin
          o_data_retry <= 1'b1;
          retried      <= 1'b1;
        end
        else
          o_data_ack <= 1'b1;
        if (beat == nb && !(rd && i_retry_en && !retried))
          retried <= 1'b0;
      end
    end
  end
endmodule : sbt_far_model
`default_nettype wire

/* bench/tb_sys_bus_tenure_master.sv */
// bench: random transfers through the master against the far model
// assumes the far model file is compiled first
`default_nettype none
module tb_sys_bus_tenure_master;
  import sbt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk, i_rst_b, i_req_valid, pk, rr, rt, eg;
  sbt_req_t i_req;
  logic [63:0] i_wdata, o_dbus_out, o_rdata, dbi;
  logic ag, dg, aa, ar, da, dr, eok, o_req_ready, o_abus_req, o_dbus_req, o_dbus_oe_b;
  logic o_rdata_valid, o_wdata_take, o_done, o_ext_fail;
  sbt_abus_t o_abus;
  int fails, comparisons, seed, wi, wa;
  logic [63:0] erd[$];
  logic efl[$];
  sbt_master i_dut (.i_mclk, .i_rst_b, .i_req_valid, .i_req, .i_wdata, .i_abus_grant(ag),
    .i_dbus_grant(dg), .i_addr_ack(aa), .i_addr_rerun(ar), .i_data_ack(da), .i_data_retry(dr),
    .i_ext_reply_ok(eok), .i_dbus_in(dbi), .o_req_ready, .o_abus_req, .o_dbus_req, .o_abus,
    .o_dbus_out, .o_dbus_oe_b, .o_rdata, .o_rdata_valid, .o_wdata_take, .o_done, .o_ext_fail);
  sbt_far_model i_far (.i_mclk, .i_rst_b, .i_park(pk), .i_rerun_en(rr), .i_retry_en(rt),
    .i_ext_good(eg), .i_abus_req(o_abus_req), .i_dbus_req(o_dbus_req), .i_abus(o_abus),
    .i_dbus_oe_b(o_dbus_oe_b), .o_abus_grant(ag), .o_dbus_grant(dg), .o_addr_ack(aa),
    .o_addr_rerun(ar), .o_data_ack(da), .o_data_retry(dr), .o_ext_reply_ok(eok), .o_dbus_in(dbi));
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [63:0] wpat(input int n);
    return {32'hC0DE0000, n[31:0]};
  endfunction : wpat
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic finish_test();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic xfer(input sbt_req_t r, input logic bad);
    int k;
    logic [31:0] b;
    k = 0;
    while (o_req_ready !== 1'b1 && k < 300)
    begin
      @(posedge i_mclk);
      #1 k++;
    end
    b = (r.kind == SBT_BURST) ? {r.addr[31:5], 5'h00} : {r.addr[31:3], 3'h0};
    if (r.kind != SBT_ADDR_ONLY && !r.write && !bad)
      for (k = 0; k < ((r.kind == SBT_BURST) ? 4 : 1); k++)
        erd.push_back({b + 32'(8 * k), ~(b + 32'(8 * k))});
    efl.push_back(bad);
    i_req = r;
    i_req_valid = 1'b1;
    @(posedge i_mclk);
    #1 i_req_valid = 1'b0;
    k = 0;
    while (o_abus.valid !== 1'b1 && k < 300)
    begin
      @(posedge i_mclk);
      #1 k++;
    end
    chk(o_abus.kind === r.kind && o_abus.intent === r.intent && o_abus.ext === r.ext, "qual");
    chk(r.kind == SBT_BURST ? o_abus.be === 8'hFF && o_abus.addr[31:5] === r.addr[31:5]
        : o_abus.addr === r.addr && o_abus.be === r.be, "addr");
    k = 0;
    while (o_done !== 1'b1 && k < 300)
    begin
      @(posedge i_mclk);
      #1 k++;
    end
    chk(k < 300, "done");
  endtask : xfer
  // ************************************************************
  // result watcher
  // ************************************************************
  always @(posedge i_mclk)
  begin
    if (i_rst_b && o_rdata_valid)
      chk(erd.size() > 0 && o_rdata === erd.pop_front(), "rdata");
    if (i_rst_b && o_done)
      chk(efl.size() > 0 && o_ext_fail === efl.pop_front(), "ext");
    if (i_rst_b && da && !o_dbus_oe_b)
    begin
      chk(o_dbus_out === wpat(wa), "wdata");
      wa++;
    end
    if (i_rst_b && o_wdata_take)
    begin
      wi++;
      i_wdata <= #1 wpat(wi);
    end
  end
  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  initial
  begin
    #100000 fails++;
    finish_test();
  end
  // ************************************************************
  // main sequence: every kind, intent, park, rerun, retry, ext
  // ************************************************************
  initial
  begin
    sbt_req_t r;
    int lo;
    seed = 32'h45490B3E;
    {fails, comparisons, wi, wa, pk, rr, rt, eg, i_req_valid} = '0;
    i_req = '0;
    i_wdata = wpat(0);
    i_rst_b = 1'b0;
    repeat (16) @(posedge i_mclk);
    #1 i_rst_b = 1'b1;
    for (int n = 0; n < 36; n++)
    begin
      r.kind = sbt_kind_t'(n % 3);
      r.intent = sbt_intent_t'(2'(n / 3));
      r.addr = $random(seed);
      r.write = r.kind != SBT_ADDR_ONLY && n[3];
      r.ext = !r.write && r.kind != SBT_ADDR_ONLY && n % 4 == 1;
      lo = r.addr[2:0];
      r.be = 8'(((9'h1 << ($unsigned($random(seed)) % (8 - lo) + 1)) - 9'h1) << lo);
      pk = n[2];
      rr = n % 5 == 1;
      rt = n % 4 == 3;
      eg = 1'($random(seed));
      xfer(r, r.ext && !eg);
    end
    repeat (4) @(posedge i_mclk);
    chk(erd.size() == 0 && efl.size() == 0, "left");
    finish_test();
  end
endmodule : tb_sys_bus_tenure_master
`default_nettype wire

/* core/sbt_master.sv */
// system bus tenure master: address and data tenures for one bus master
// assumes arbiter grants and slave acks are synchronous to i_mclk
`default_nettype none
module sbt_master
  import sbt_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rst_b,
  input  wire logic              i_req_valid,
  input  wire sbt_req_t          i_req,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_abus_grant,
  input  wire logic              i_dbus_grant,
  input  wire logic              i_addr_ack,
  input  wire logic              i_addr_rerun,
  input  wire logic              i_data_ack,
  input  wire logic              i_data_retry,
  input  wire logic              i_ext_reply_ok,
  input  wire logic [DATA_W-1:0] i_dbus_in,
  output logic                   o_req_ready,
  output logic                   o_abus_req,
  output logic                   o_dbus_req,
  output sbt_abus_t              o_abus,
  output logic [DATA_W-1:0]      o_dbus_out,
  output logic                   o_dbus_oe_b,
  output logic [DATA_W-1:0]      o_rdata,
  output logic                   o_rdata_valid,
  output logic                   o_wdata_take,
  output logic                   o_done,
  output logic                   o_ext_fail
);
  // ************************************************************
  // tenure sequencer
  // ************************************************************
  sbt_state_t        state, next_state;
  sbt_req_t          cur, next_cur;
  logic [1:0]        beat, next_beat;
  logic              next_req_ready, next_abus_req, next_dbus_req, next_dbus_oe_b;
  logic              next_rdata_valid, next_wdata_take, next_done, next_ext_fail;
  sbt_abus_t         next_abus;
  logic [DATA_W-1:0] next_dbus_out, next_rdata;

  always_comb
  begin
    next_state       = state;
    next_cur         = cur;
    next_beat        = beat;
    next_req_ready   = 1'b0;
    next_abus_req    = o_abus_req;
    next_dbus_req    = o_dbus_req;
    next_abus        = '0;
    next_dbus_out    = o_dbus_out;
    next_dbus_oe_b   = 1'b1;
    next_rdata       = o_rdata;
    next_rdata_valid = 1'b0;
    next_wdata_take  = 1'b0;
    next_done        = 1'b0;
    next_ext_fail    = 1'b0;
    case (state)
      SBT_IDLE:
      begin
        next_req_ready = 1'b1;
        if (i_req_valid && o_req_ready)
        begin
          next_req_ready = 1'b0;
          next_cur       = i_req;
          next_beat      = 2'h0;
          if (i_req.kind == SBT_BURST)
          begin
            // one coherence granule per burst, so snoopers see whole sectors
            next_cur.addr = i_req.addr & ~ADDR_W'(LINE_MASK);
            next_cur.be   = '1;
          end
          if (i_abus_grant)
            next_state = SBT_AXFER;
          else
          begin
            next_state    = SBT_AREQ;
            next_abus_req = 1'b1;
          end
        end
      end
      SBT_AREQ:
        if (i_abus_grant)
        begin
          next_abus_req = 1'b0;
          next_state    = SBT_AXFER;
        end
      SBT_AXFER:
      begin
        next_abus.valid  = 1'b1;
        next_abus.kind   = cur.kind;
        next_abus.write  = cur.write;
        next_abus.ext    = cur.ext;
        next_abus.intent = cur.intent;
        next_abus.addr   = cur.addr;
        next_abus.be     = cur.be;
        next_state       = SBT_ATERM;
      end
      SBT_ATERM:
      begin
        next_abus = o_abus;
        if (i_addr_rerun)
        begin
          next_abus     = '0;
          next_abus_req = 1'b1;
          next_state    = SBT_AREQ;
        end
        else if (i_addr_ack)
        begin
          next_abus = '0;
          if (cur.ext && !i_ext_reply_ok)
          begin
            next_ext_fail = 1'b1;
            next_done     = 1'b1;
            next_state    = SBT_IDLE;
          end
          else if (cur.kind == SBT_ADDR_ONLY)
          begin
            next_done  = 1'b1;
            next_state = SBT_IDLE;
          end
          else if (i_dbus_grant)
            next_state = SBT_DXFER;
          else
          begin
            next_dbus_req = 1'b1;
            next_state    = SBT_DREQ;
          end
          // no beat is consumed when a refused direct-store access ends early
          if (cur.write && cur.kind != SBT_ADDR_ONLY && !(cur.ext && !i_ext_reply_ok))
          begin
            next_dbus_out   = i_wdata;
            next_wdata_take = 1'b1;
          end
        end
      end
      SBT_DREQ:
        if (i_dbus_grant)
        begin
          next_dbus_req = 1'b0;
          next_state    = SBT_DXFER;
        end
      SBT_DXFER:
      begin
        next_dbus_oe_b = !cur.write;
        if (i_data_retry)
        begin
          next_beat      = 2'h0;
          next_dbus_oe_b = 1'b1;
          next_dbus_req  = 1'b1;
          next_state     = SBT_DREQ;
        end
        else if (i_data_ack)
        begin
          if (!cur.write)
          begin
            next_rdata       = i_dbus_in;
            next_rdata_valid = 1'b1;
          end
          if (cur.kind == SBT_BURST && beat != LAST_BEAT)
          begin
            next_beat = beat + 2'h1;
            if (cur.write)
            begin
              next_dbus_out   = i_wdata;
              next_wdata_take = 1'b1;
            end
          end
          else
          begin
            next_dbus_oe_b = 1'b1;
            next_done      = 1'b1;
            next_state     = SBT_IDLE;
          end
        end
      end
      default:
        next_state = SBT_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state         <= SBT_IDLE;
      cur           <= '0;
      beat          <= 2'h0;
      o_req_ready   <= 1'b0;
      o_abus_req    <= 1'b0;
      o_dbus_req    <= 1'b0;
      o_abus        <= '0;
      o_dbus_out    <= '0;
      o_dbus_oe_b   <= 1'b1;
      o_rdata       <= '0;
      o_rdata_valid <= 1'b0;
      o_wdata_take  <= 1'b0;
      o_done        <= 1'b0;
      o_ext_fail    <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      cur           <= next_cur;
      beat          <= next_beat;
      o_req_ready   <= next_req_ready;
      o_abus_req    <= next_abus_req;
      o_dbus_req    <= next_dbus_req;
      o_abus        <= next_abus;
      o_dbus_out    <= next_dbus_out;
      o_dbus_oe_b   <= next_dbus_oe_b;
      o_rdata       <= next_rdata;
      o_rdata_valid <= next_rdata_valid;
      o_wdata_take  <= next_wdata_take;
      o_done        <= next_done;
      o_ext_fail    <= next_ext_fail;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  park_skip_req_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (state == SBT_IDLE && i_req_valid && o_req_ready && i_abus_grant) |=> (state == SBT_AXFER && !o_abus_req))
    else $error("parked master did not go straight to transfer");
  addr_drive_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (state == SBT_AXFER) |=> (o_abus.valid && o_abus.addr == $past(cur.addr)))
    else $error("address not driven in transfer phase");
  rerun_rereq_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (state == SBT_ATERM && i_addr_rerun) |=> (o_abus_req && state == SBT_AREQ && !o_done))
    else $error("rerun did not re-request bus");
  addr_only_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (state == SBT_ATERM && i_addr_ack && !i_addr_rerun && cur.kind == SBT_ADDR_ONLY && !cur.ext)
    |=> (o_done && !o_dbus_req && state == SBT_IDLE))
    else $error("address-only op entered data tenure");
  data_retry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (state == SBT_DXFER && i_data_retry) |=> (state == SBT_DREQ && beat == 2'h0 && !o_done))
    else $error("data retry not repeated");
  burst_beats_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (state == SBT_DXFER && i_data_ack && !i_data_retry && cur.kind == SBT_BURST && beat != LAST_BEAT)
    |=> (beat == $past(beat) + 2'h1 && !o_done))
    else $error("burst beat order broken");
  write_drive_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!o_dbus_oe_b) |-> (cur.write && $past(state) == SBT_DXFER))
    else $error("data bus driven outside write transfer");
  read_capture_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (state == SBT_DXFER && i_data_ack && !i_data_retry && !cur.write) |=> (o_rdata_valid && o_rdata == $past(i_dbus_in)))
    else $error("read data not captured");
  burst_align_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (o_abus.valid && o_abus.kind == SBT_BURST) |-> (o_abus.addr[4:0] == 5'h00))
    else $error("burst address not aligned to 32 bytes");
  ext_reply_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (state == SBT_ATERM && i_addr_ack && !i_addr_rerun && cur.ext && !i_ext_reply_ok) |=> (o_ext_fail && o_done))
    else $error("missing positive reply not flagged");
endmodule : sbt_master
`default_nettype wire

/* core/sbt_pkg.sv */
// package for the system bus tenure master: widths, beat counts, masks, types, state encoding
// assumes a single rising-edge bus clock shared by all agents
`default_nettype none
package sbt_pkg;
  // ************************************************************
  // widths
  // ************************************************************
  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 64;
  localparam int BEATS       = 4;
  localparam int BE_W        = 8;
  localparam logic [4:0] LINE_MASK = 5'h1F;
  localparam logic [2:0] DW_MASK   = 3'h7;
  localparam logic [4:0] DW_STEP   = 5'h08;
  localparam logic [1:0] LAST_BEAT = 2'h3;

  // ************************************************************
  // transfer kinds and snoop intent
  // ************************************************************
  typedef enum logic [1:0] {
    SBT_SINGLE    = 2'h0,
    SBT_BURST     = 2'h1,
    SBT_ADDR_ONLY = 2'h2
  } sbt_kind_t;

  typedef enum logic [1:0] {
    SBT_INT_NONE  = 2'h0,
    SBT_INT_READ  = 2'h1,
    SBT_INT_OWN   = 2'h2,
    SBT_INT_FLUSH = 2'h3
  } sbt_intent_t;

  // request from the core side
  typedef struct packed {
    sbt_kind_t             kind;
    logic                  write;
    logic                  ext;
    sbt_intent_t           intent;
    logic [ADDR_W-1:0]     addr;
    logic [BE_W-1:0]       be;
  } sbt_req_t;

  // address tenure qualifiers driven on the bus
  typedef struct packed {
    logic                  valid;
    sbt_kind_t             kind;
    logic                  write;
    logic                  ext;
    sbt_intent_t           intent;
    logic [ADDR_W-1:0]     addr;
    logic [BE_W-1:0]       be;
  } sbt_abus_t;

  typedef enum logic [2:0] {
    SBT_IDLE  = 3'h0,
    SBT_AREQ  = 3'h1,
    SBT_AXFER = 3'h2,
    SBT_ATERM = 3'h3,
    SBT_DREQ  = 3'h4,
    SBT_DXFER = 3'h5
  } sbt_state_t;
endpackage : sbt_pkg
`default_nettype wire
